// *** rtl/pin_mux_pkg.sv ***
package pin_mux_pkg;

	localparam int NUM_PINS = 16;
	localparam int NUM_REGS = 10;
	localparam int NUM_ENC  = 4;

	// Byte offsets of the selection registers on the register bus.
	localparam logic [5:0] OFS_PIN_SELECT_0 = 6'h00;
	localparam logic [5:0] OFS_PIN_SELECT_1 = 6'h04;
	localparam logic [5:0] OFS_PIN_SELECT_2 = 6'h08;
	localparam logic [5:0] OFS_PIN_SELECT_3 = 6'h0C;
	localparam logic [5:0] OFS_PIN_SELECT_4 = 6'h10;
	localparam logic [5:0] OFS_PIN_SELECT_5 = 6'h14;
	localparam logic [5:0] OFS_PIN_SELECT_6 = 6'h18;
	localparam logic [5:0] OFS_ENC_FILTER   = 6'h20;
	localparam logic [5:0] OFS_KILL_SOURCE  = 6'h24;

	// Word indices derived from the offsets above.
	localparam logic [3:0] IDX_PIN_SELECT_2 = 4'h2;
	localparam logic [3:0] IDX_LAST_PIN_SEL = 4'h6;
	localparam logic [3:0] IDX_ENC_FILTER   = 4'h8;
	localparam logic [3:0] IDX_KILL_SOURCE  = 4'h9;

	// Values after reset; index 7 is a hole in the map and reads as zero.
	localparam logic [31:0] SEL_RESET [NUM_REGS] = '{
		32'h0000_0100, 32'h0101_0101, 32'h0001_0101, 32'h0101_0001, 32'h0001_0101,
		32'h0000_0100, 32'h0000_0100, 32'h0000_0000, 32'h0101_0101, 32'h0000_0001
	};

	// Field positions in the filter and kill-source registers.
	localparam int ENC_SYNC_BIT    = 0;
	localparam int ENC_QUAL_BIT    = 1;
	localparam int ENC_LANE_STRIDE = 8;
	localparam int KILL_DIRECT_BIT = 0;
	localparam int KILL_ENC_BIT    = 1;

	// Saturation value of the 6-bit qualification counter.
	localparam logic [5:0] QUAL_MAX = 6'h3F;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Per shared pin: owning register, byte lane, and whether a third option exists.
	localparam logic [3:0] PIN_REG [NUM_PINS] = '{
		4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
		4'h6, 4'h3, 4'h4, 4'h5, 4'h3, 4'h4, 4'h3, 4'h4
	};
	localparam logic [1:0] PIN_LANE [NUM_PINS] = '{
		2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2,
		2'h1, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h2
	};
	localparam logic [NUM_PINS-1:0] PIN_HAS_THIRD = 16'h0B40;

	// Pin index of the shared pin that carries port A bit 7 or timer channel 29.
	localparam int PIN_IDX_18 = 7;

	typedef enum logic {
		ST_IDLE = 1'h0,
		ST_ACK  = 1'h1
	} bus_state_e;

endpackage

// *** rtl/pin_mux.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - After reset every shared pin drives its default function.
// - Each pin offers default plus up to two alternates, one select bit each.
// - Setting exactly an option's select bit routes that option to the pin.
// - Only outputs are muxed; a pin's input reaches every sharing module.
// - Pin 18 shows port A bit 7 by default; its default bit resets set.
// - Selection registers accept writes only in privileged mode.
// - A nonprivileged write answers with an error and changes nothing.
// - An all-zero register selects the default on all its pins.
// - More than one bit set in a pin's byte gives the default function.
// - Filter sync bit set: encoder input is double-synchronised only.
// - Sync bit clear, qualify bit set: synchronised then 6-bit qualified.
// - Both filter bits clear behaves like synchronisation only.
// - Encoder B, index and strobe use lanes 1, 2 and 3 the same way.
// - Kill direct bit set: port A bit 5 drives the timer kill input.
// - Direct clear, encoder bit set: inverted, synchronised error drives kill.
// - Both kill bits clear behaves like the direct port A bit 5 source.
module pin_mux
	import pin_mux_pkg::*;
(
	input  wire logic                              sys_clk,
	input  wire logic                              sys_rst,
	input  wire logic [5:0]                        address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic [31:0]                       writedata,
	input  wire logic [3:0]                        byteenable,
	input  wire logic                              bus_privileged,
	output logic      [31:0]                       readdata,
	output logic                                   waitrequest,
	output logic      [1:0]                        response,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_default_out,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_default_oe,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_alt1_out,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_alt1_oe,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_alt2_out,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] func_alt2_oe,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pin_out,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_in,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] shared_pin_in,
	input  wire logic [pin_mux_pkg::NUM_ENC-1:0]  encoder_in,
	output logic      [pin_mux_pkg::NUM_ENC-1:0]  encoder_filtered,
	input  wire logic                              port_a_bit5,
	input  wire logic                              encoder_error_signal,
	output logic                                   timer_output_kill_n
);
	import pin_mux_pkg::*;

	// Option decode for one pin's byte: only a single set bit picks an alternate.
	function automatic logic [1:0] pick_option(input logic [7:0] lane, input logic third);
		logic [1:0] opt;
		opt = 2'h0;
		case (lane)
			8'h02:   opt = 2'h1;
			8'h04:   opt = third ? 2'h2 : 2'h0;
			default: opt = 2'h0;
		endcase
		return opt;
	endfunction

	// Byte-enable expansion, shared by every register write.
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	bus_state_e        state_r;
	logic       [31:0] sel_r [NUM_REGS];
	logic       [31:0] readdata_r;
	logic              waitrequest_r;
	logic       [1:0]  response_r;

	wire logic  [3:0]  reg_idx     = address[5:2];
	wire logic         addr_mapped = (address[1:0] == 2'h0) &&
	                                 ((reg_idx <= IDX_LAST_PIN_SEL) ||
	                                  (reg_idx == IDX_ENC_FILTER) ||
	                                  (reg_idx == IDX_KILL_SOURCE));
	wire logic         req_seen    = (read || write) && (state_r == ST_IDLE);
	wire logic         bus_err     = !addr_mapped || (write && !bus_privileged);
	wire logic         wr_commit   = (state_r == ST_ACK) && write && addr_mapped &&
	                                 bus_privileged;
	wire logic  [31:0] rd_word     = addr_mapped ? sel_r[reg_idx] : 32'h0000_0000;
	wire logic  [31:0] wr_mask     = lane_mask(byteenable);

	// One wait cycle per access keeps read data and the error answer registered.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_r       <= ST_IDLE;
			waitrequest_r <= 1'h1;
			readdata_r    <= 32'h0000_0000;
			response_r    <= RESP_OKAY;
		end
		else if (req_seen)
		begin
			state_r       <= ST_ACK;
			waitrequest_r <= 1'h0;
			readdata_r    <= read ? rd_word : 32'h0000_0000;
			response_r    <= bus_err ? RESP_SLVERR : RESP_OKAY;
		end
		else
		begin
			state_r       <= ST_IDLE;
			waitrequest_r <= 1'h1;
			readdata_r    <= 32'h0000_0000;
			response_r    <= RESP_OKAY;
		end
	end

	assign readdata    = readdata_r;
	assign waitrequest = waitrequest_r;
	assign response    = response_r;

	// Reserved bits are stored as written; the pads behind them are not ours to guard.
	genvar r;
	generate
		for (r = 0; r < NUM_REGS; r++)
		begin : g_reg
			wire logic        wr_this = wr_commit && (reg_idx == 4'(r));
			wire logic [31:0] sel_nxt = (sel_r[r] & ~wr_mask) | (writedata & wr_mask);
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
					sel_r[r] <= SEL_RESET[r];
				else if (wr_this)
					sel_r[r] <= sel_nxt;
			end
		end
	endgenerate

	// Output pin multiplexing; the registered stage keeps every pin glitch free.
	logic [NUM_PINS-1:0] pin_out_r;
	logic [NUM_PINS-1:0] pin_oe_r;
	logic [NUM_PINS-1:0] shared_in_r;

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++)
		begin : g_pin
			wire logic [31:0] owner   = sel_r[PIN_REG[p]];
			wire logic [7:0]  lane    = owner[8*PIN_LANE[p] +: 8];
			wire logic [1:0]  opt     = pick_option(lane, PIN_HAS_THIRD[p]);
			wire logic        out_nxt = (opt == 2'h1) ? func_alt1_out[p] :
			                            (opt == 2'h2) ? func_alt2_out[p] :
			                                            func_default_out[p];
			wire logic        oe_nxt  = (opt == 2'h1) ? func_alt1_oe[p] :
			                            (opt == 2'h2) ? func_alt2_oe[p] :
			                                            func_default_oe[p];
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
				begin
					pin_out_r[p]   <= 1'h0;
					pin_oe_r[p]    <= 1'h0;
					shared_in_r[p] <= 1'h0;
				end
				else
				begin
					pin_out_r[p]   <= out_nxt;
					pin_oe_r[p]    <= oe_nxt;
					shared_in_r[p] <= pin_in[p];
				end
			end
		end
	endgenerate

	assign pin_out       = pin_out_r;
	assign pin_oe        = pin_oe_r;
	assign shared_pin_in = shared_in_r;

	// Encoder input filters, one per input, selected by one byte lane each.
	logic [NUM_ENC-1:0] enc_s1_r;
	logic [NUM_ENC-1:0] enc_s2_r;
	logic [NUM_ENC-1:0] enc_qual_r;
	logic [NUM_ENC-1:0] enc_out_r;
	logic [5:0]         enc_cnt_r [NUM_ENC];
	logic [NUM_ENC-1:0] enc_qmode;

	genvar e;
	generate
		for (e = 0; e < NUM_ENC; e++)
		begin : g_enc
			wire logic [7:0] lane = sel_r[IDX_ENC_FILTER][ENC_LANE_STRIDE*e +: 8];
			// Only the sync-clear, qualify-set pattern qualifies; all else is sync only.
			assign enc_qmode[e] = !lane[ENC_SYNC_BIT] && lane[ENC_QUAL_BIT];
			wire logic       differs  = enc_s2_r[e] != enc_qual_r[e];
			wire logic       saturate = differs && (enc_cnt_r[e] == QUAL_MAX);
			wire logic [5:0] cnt_nxt  = (!differs || saturate) ? 6'h00 :
			                            6'(enc_cnt_r[e] + 6'h01);
			wire logic       qual_nxt = saturate ? enc_s2_r[e] : enc_qual_r[e];
			wire logic       out_nxt  = enc_qmode[e] ? qual_nxt : enc_s2_r[e];
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
				begin
					enc_s1_r[e]   <= 1'h0;
					enc_s2_r[e]   <= 1'h0;
					enc_cnt_r[e]  <= 6'h00;
					enc_qual_r[e] <= 1'h0;
					enc_out_r[e]  <= 1'h0;
				end
				else
				begin
					enc_s1_r[e]   <= encoder_in[e];
					enc_s2_r[e]   <= enc_s1_r[e];
					enc_cnt_r[e]  <= cnt_nxt;
					enc_qual_r[e] <= qual_nxt;
					enc_out_r[e]  <= out_nxt;
				end
			end
		end
	endgenerate

	assign encoder_filtered = enc_out_r;

	// Timer kill source. The synchroniser resets to the inactive high level.
	logic err_s1_r;
	logic err_s2_r;
	logic kill_n_r;

	wire logic kill_direct = sel_r[IDX_KILL_SOURCE][KILL_DIRECT_BIT] ||
	                         !sel_r[IDX_KILL_SOURCE][KILL_ENC_BIT];
	wire logic kill_nxt    = kill_direct ? port_a_bit5 : err_s2_r;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			err_s1_r <= 1'h1;
			err_s2_r <= 1'h1;
			kill_n_r <= 1'h1;
		end
		else
		begin
			err_s1_r <= !encoder_error_signal;
			err_s2_r <= err_s1_r;
			kill_n_r <= kill_nxt;
		end
	end

	assign timer_output_kill_n = kill_n_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	ack_latency_a : assert property (
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("Access not answered after exactly one wait cycle.");

	nonpriv_error_a : assert property (
		write && !waitrequest && !bus_privileged |-> response == RESP_SLVERR)
		else $error("Nonprivileged write did not return an error.");

	nonpriv_keep_a : assert property (
		write && !waitrequest && !bus_privileged && address == OFS_PIN_SELECT_2
		|=> sel_r[IDX_PIN_SELECT_2] == $past(sel_r[IDX_PIN_SELECT_2]))
		else $error("Nonprivileged write changed a selection register.");

	priv_write_a : assert property (
		write && !waitrequest && bus_privileged && address == OFS_PIN_SELECT_2 &&
		byteenable == 4'hF |=> sel_r[IDX_PIN_SELECT_2] == $past(writedata))
		else $error("Privileged write not stored.");

	reset_default_a : assert property (
		$fell(sys_rst) |-> sel_r[IDX_PIN_SELECT_2] == SEL_RESET[IDX_PIN_SELECT_2] &&
		pin_out[PIN_IDX_18] == $past(func_default_out[PIN_IDX_18]))
		else $error("Pin 18 not on its default function after reset.");

	alt_route_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2][23:16]) == 8'h02 |->
		pin_out[PIN_IDX_18] == $past(func_alt1_out[PIN_IDX_18]))
		else $error("Pin 18 alternate not routed.");

	multi_bit_a : assert property (
		$countones($past(sel_r[IDX_PIN_SELECT_2][23:16])) != 1 |->
		pin_out[PIN_IDX_18] == $past(func_default_out[PIN_IDX_18]))
		else $error("Illegal pin 18 byte did not fall back to default.");

	sync_path_a : assert property (
		!enc_qmode[0] && $past(!enc_qmode[0]) && $past(!enc_qmode[0], 2) &&
		!$past(sys_rst, 3) |-> encoder_filtered[0] == $past(encoder_in[0], 3))
		else $error("Sync-only encoder path latency wrong.");

	// The output may jump to the held level in the cycle after a mode switch.
	qual_hold_a : assert property (
		enc_qmode[0] && $past(enc_qmode[0]) && $past(enc_qmode[0], 2) &&
		$changed(encoder_filtered[0]) |-> $past(enc_cnt_r[0]) == QUAL_MAX)
		else $error("Qualified encoder input changed before saturation.");

	shared_in_a : assert property (
		!$past(sys_rst) |->
		shared_pin_in == $past(pin_in))
		else $error("Pad input not passed to the sharing modules.");

	oe_alt_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2][23:16]) == 8'h02 |->
		pin_oe[PIN_IDX_18] == $past(func_alt1_oe[PIN_IDX_18]))
		else $error("Pin 18 alternate enable not routed.");

	default_hold_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2][23:16]) == 8'h01 && !$past(sys_rst) |->
		pin_out[PIN_IDX_18] == $past(func_default_out[PIN_IDX_18]))
		else $error("Pin 18 left its default function.");

	zero_reg_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2]) == 32'h0000_0000 && !$past(sys_rst) |->
		pin_oe[PIN_IDX_18] == $past(func_default_oe[PIN_IDX_18]))
		else $error("All-zero register did not select the default.");

	third_opt_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2][15:8]) == 8'h04 |->
		pin_out[6] == $past(func_alt2_out[6]) && pin_oe[6] == $past(func_alt2_oe[6]))
		else $error("Third option of a three-way pin not routed.");

	no_third_a : assert property (
		$past(sel_r[IDX_PIN_SELECT_2][23:16]) == 8'h04 |->
		pin_out[PIN_IDX_18] == $past(func_default_out[PIN_IDX_18]))
		else $error("Bit without an option did not give the default.");

	read_ok_a : assert property (
		read && !waitrequest && address == OFS_PIN_SELECT_2 |->
		response == RESP_OKAY)
		else $error("Selection register read refused.");

	lane_keep_a : assert property (
		write && !waitrequest && bus_privileged && address == OFS_PIN_SELECT_2 &&
		byteenable == 4'h1 |=> sel_r[IDX_PIN_SELECT_2][31:8] == $past(sel_r[IDX_PIN_SELECT_2][31:8]))
		else $error("Disabled byte lanes were written.");

	store_filter_a : assert property (
		write && !waitrequest && bus_privileged && address == OFS_ENC_FILTER &&
		byteenable == 4'hF |=> sel_r[IDX_ENC_FILTER] == $past(writedata))
		else $error("Filter register not stored as written.");

	sync_lane1_a : assert property (
		$past(sel_r[IDX_ENC_FILTER][9:8]) == 2'h0 && !$past(sys_rst) && !$past(sys_rst, 2) &&
		!$past(sys_rst, 3) |-> encoder_filtered[1] == $past(encoder_in[1], 3))
		else $error("Encoder B with both bits clear is not sync only.");

	kill_fallback_a : assert property (
		$past(sel_r[IDX_KILL_SOURCE][1:0]) == 2'h0 |->
		timer_output_kill_n == $past(port_a_bit5))
		else $error("Both kill bits clear did not pick port A bit 5.");

	reset_clear_a : assert property (
		$fell(sys_rst) |-> encoder_filtered == 4'h0 && timer_output_kill_n &&
		shared_pin_in == 16'h0000)
		else $error("Filter and kill state not cleared by reset.");

	kill_direct_a : assert property (
		$past(kill_direct) |-> timer_output_kill_n == $past(port_a_bit5))
		else $error("Kill input does not follow port A bit 5.");

	kill_encoder_a : assert property (
		!kill_direct && $past(!kill_direct) && !$past(sys_rst, 3) |->
		timer_output_kill_n == !$past(encoder_error_signal, 3))
		else $error("Kill input does not follow inverted encoder error.");

	cover_priv_write : cover property (write && !waitrequest && bus_privileged);
	cover_nonpriv    : cover property (write && !waitrequest && !bus_privileged);
	cover_alt_pin18  : cover property (sel_r[IDX_PIN_SELECT_2][23:16] == 8'h02);
	cover_qualified  : cover property (enc_qmode[0] && $changed(encoder_filtered[0]));
	cover_enc_kill   : cover property (!kill_direct && !timer_output_kill_n);

endmodule

// *** sim/periph_model.sv ***
`timescale 1ns/100ps
module periph_model
	import pin_mux_pkg::*;
(
	input  wire logic                             sys_clk,
	input  wire logic                             sys_rst,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_default_out,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_default_oe,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_alt1_out,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_alt1_oe,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_alt2_out,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] func_alt2_oe,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pin_in
);
	import pin_mux_pkg::*;
	logic [NUM_PINS-1:0] pad_r;
	// Every option shows its own out and enable pair, so a wrong pick is visible.
	assign func_default_out = 16'h0000;
	assign func_default_oe  = 16'hFFFF;
	assign func_alt1_out    = 16'hFFFF;
	assign func_alt1_oe     = 16'hFFFF;
	assign func_alt2_out    = 16'hFFFF;
	assign func_alt2_oe     = 16'h0000;
	// The pads flip every cycle, so a stale copy of the inputs cannot pass.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			pad_r <= 16'hA5C3;
		else
			pad_r <= ~pad_r;
	end
	assign pin_in = pad_r;
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
	import pin_mux_pkg::*;
	logic                sys_clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic [5:0]          address = 6'h00;
	logic                read = 1'b0;
	logic                write = 1'b0;
	logic [31:0]         writedata = 32'h0000_0000;
	logic [3:0]          byteenable = 4'hF;
	logic                bus_privileged = 1'b1;
	logic [31:0]         readdata;
	logic                waitrequest;
	logic [1:0]          response;
	logic [NUM_PINS-1:0] func_default_out, func_default_oe, func_alt1_out, func_alt1_oe;
	logic [NUM_PINS-1:0] func_alt2_out, func_alt2_oe, pin_out, pin_oe, pin_in, shared_pin_in;
	logic [3:0]          encoder_in = 4'h0;
	logic [3:0]          encoder_filtered;
	logic                port_a_bit5 = 1'b1;
	logic                encoder_error_signal = 1'b0;
	logic                timer_output_kill_n;
	logic [31:0]         shadow [NUM_REGS];
	logic [31:0]         rd;
	logic [1:0]          rs;
	int                  err_count = 0;
	int                  n_compared = 0;

	always #20 sys_clk = ~sys_clk;

	pin_mux u_pin_mux (.sys_clk, .sys_rst, .address, .read, .write, .writedata, .byteenable,
		.bus_privileged, .readdata, .waitrequest, .response, .func_default_out,
		.func_default_oe, .func_alt1_out, .func_alt1_oe, .func_alt2_out, .func_alt2_oe,
		.pin_out, .pin_oe, .pin_in, .shared_pin_in, .encoder_in, .encoder_filtered,
		.port_a_bit5, .encoder_error_signal, .timer_output_kill_n);
	periph_model u_periph_model (.sys_clk, .sys_rst, .func_default_out, .func_default_oe,
		.func_alt1_out, .func_alt1_oe, .func_alt2_out, .func_alt2_oe, .pin_in);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic pv);
		int i;
		@(posedge sys_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		bus_privileged <= pv;
		for (i = 0; i < 50; i++)
		begin
			@(posedge sys_clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (i == 50)
		begin
			chk("waitrequest", 32'h0, 32'h1);
			test_done();
		end
		rd = readdata;
		rs = response;
		read <= 1'b0;
		write <= 1'b0;
		if (wr && pv && a[5:2] <= IDX_KILL_SOURCE && a[5:2] != 4'h7)
			for (i = 0; i < 4; i++)
				if (be[i])
					shadow[a[5:2]][i*8 +: 8] = d[i*8 +: 8];
	endtask

	function automatic logic [1:0] opt(input int p);
		logic [7:0] b;
		b = shadow[PIN_REG[p]][PIN_LANE[p]*8 +: 8];
		if (b == 8'h02)
			return 2'h1;
		if (b == 8'h04 && PIN_HAS_THIRD[p])
			return 2'h2;
		return 2'h0;
	endfunction

	task automatic chk_pins;
		logic [15:0] eo;
		logic [15:0] ee;
		for (int p = 0; p < NUM_PINS; p++)
		begin
			eo[p] = opt(p) != 2'h0;
			ee[p] = opt(p) != 2'h2;
		end
		chk("pin out", {16'h0000, eo}, {16'h0000, pin_out});
		chk("pin oe", {16'h0000, ee}, {16'h0000, pin_oe});
		chk("pad inputs", {16'h0000, ~pin_in}, {16'h0000, shared_pin_in});
	endtask

	task automatic t_reset;
		for (int r = 0; r < NUM_REGS; r++)
		begin
			bus(1'b0, 6'(r * 4), 32'h0000_0000, 4'hF, 1'b1);
			chk("reset value", SEL_RESET[r], rd);
			chk("read resp", {30'h0, r == 7 ? RESP_SLVERR : RESP_OKAY}, {30'h0, rs});
			if (r == 2)
				chk("pin 18 default bit", 32'h1, {31'h0, rd[16]});
		end
		chk_pins();
	endtask

	task automatic t_select;
		logic [31:0] pat [5] = '{32'h0202_0202, 32'h0404_0404, 32'h0306_0500,
			32'h0402_0100, 32'h0000_0000};
		for (int k = 0; k < 5; k++)
		begin
			for (int r = 0; r < 7; r++)
				bus(1'b1, 6'(r * 4), pat[k], 4'hF, 1'b1);
			edges(2);
			chk_pins();
		end
		bus(1'b1, OFS_PIN_SELECT_2, 32'h0002_0000, 4'hF, 1'b1);
		edges(2);
		chk("pin 18 timer", 32'h3, {30'h0, pin_out[PIN_IDX_18], pin_oe[PIN_IDX_18]});
	endtask

	task automatic t_priv;
		bus(1'b1, OFS_PIN_SELECT_2, 32'h0000_0002, 4'hF, 1'b0);
		chk("user write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		bus(1'b0, OFS_PIN_SELECT_2, 32'h0000_0000, 4'hF, 1'b0);
		chk("after user write", shadow[2], rd);
		bus(1'b1, OFS_PIN_SELECT_2, 32'h0000_0202, 4'h1, 1'b1);
		bus(1'b0, OFS_PIN_SELECT_2, 32'h0000_0000, 4'hF, 1'b1);
		chk("lane write", shadow[2], rd);
		bus(1'b1, 6'h2C, 32'h0000_0001, 4'hF, 1'b1);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		edges(2);
		chk_pins();
	endtask

	task automatic t_kill;
		@(posedge sys_clk);
		port_a_bit5 <= 1'b0;
		edges(1);
		chk("kill early", 32'h1, {31'h0, timer_output_kill_n});
		edges(1);
		chk("kill direct", 32'h0, {31'h0, timer_output_kill_n});
		bus(1'b1, OFS_KILL_SOURCE, 32'h0000_0002, 4'hF, 1'b1);
		edges(5);
		chk("kill no error", 32'h1, {31'h0, timer_output_kill_n});
		encoder_error_signal <= 1'b1;
		edges(2);
		chk("kill error early", 32'h1, {31'h0, timer_output_kill_n});
		edges(3);
		chk("kill error", 32'h0, {31'h0, timer_output_kill_n});
		port_a_bit5 <= 1'b1;
		bus(1'b1, OFS_KILL_SOURCE, 32'h0000_0000, 4'hF, 1'b1);
		edges(2);
		chk("kill fallback", 32'h1, {31'h0, timer_output_kill_n});
	endtask

	task automatic t_filter;
		@(posedge sys_clk);
		encoder_in <= 4'hF;
		edges(2);
		chk("sync early", 32'h0, {28'h0, encoder_filtered});
		edges(3);
		chk("sync only", 32'hF, {28'h0, encoder_filtered});
		// Lanes 0 and 2 qualified, lane 1 both bits clear, lane 3 sync only.
		bus(1'b1, OFS_ENC_FILTER, 32'h0102_0002, 4'hF, 1'b1);
		edges(40);
		chk("qualify held", 32'hA, {28'h0, encoder_filtered});
		edges(40);
		chk("qualify passed", 32'hF, {28'h0, encoder_filtered});
		encoder_in <= 4'h0;
		@(posedge sys_clk);
		encoder_in <= 4'hF;
		edges(40);
		chk("qualify glitch", 32'hF, {28'h0, encoder_filtered});
		encoder_in <= 4'h0;
		edges(5);
		chk("lanes mixed", 32'h5, {28'h0, encoder_filtered});
	endtask

	task automatic t_rerun;
		sys_rst <= 1'b1;
		edges(2);
		chk("filter cleared", 32'h0, {28'h0, encoder_filtered});
		sys_rst <= 1'b0;
		for (int r = 0; r < NUM_REGS; r++)
			shadow[r] = SEL_RESET[r];
		t_reset();
	endtask

	initial
	begin
		for (int r = 0; r < NUM_REGS; r++)
			shadow[r] = SEL_RESET[r];
		edges(16);
		sys_rst <= 1'b0;
		t_reset();
		t_select();
		t_priv();
		t_kill();
		t_filter();
		t_rerun();
		test_done();
	end
endmodule
